/* rtl/rxsr_regs.sv */
`timescale 1ns/100ps
// Overview of operation
// - Lock gain/loss marker count equals the 3-bit threshold field plus one.
// - Timing-reference alignment is delayed 0 to 15 core cycles by a 4-bit field.
// - With resync-needs-reference set, link stays halted after resync until realigned.
// - With resync-needs-reference clear, link restarts after resync without waiting.
// - With align-always set, every timing-reference event realigns the local counter.
// - With align-always clear, only the first event after reset, or the next one in a resync wait, aligns; others ignored.
// - One multi-block-aligned flag per lane in bits 23:16, live.
// - One sync-header-aligned flag per lane in bits 7:0, live.
// - Eight 4-bit lane error nibbles in one word, lane 0 lowest.
// - Error nibble: bit 2 control char, bit 1 disparity, bit 0 invalid code, bit 3 zero.
// - Each error bit sets on any error of its type on an active lane and holds until read.
// - Reading the lane error word clears all its bits except errors arriving in that cycle.
// - Eight 4-bit debug nibbles laid out like lane 0, lane 7 on top.
// - Debug bit 3 is start of user data seen, bit 2 start of alignment sequence.
// - Debug bit 1 is code group sync, bit 0 receiving alignment characters.
// - Debug bits 3:2 latch; clear on read or reset; re-set at once if active.
// - Debug bits 1:0 show live lane condition without latching.
module rxsr_regs #(
  parameter int NUM_LANES = rxsr_pkg::LANES
) (
  // Clock and reset
  input  wire logic                                       mclk,
  input  wire logic                                       rst,
  // Register port
  input  wire rxsr_pkg::rxsr_reg_req_type                 reg_req,
  output logic [rxsr_pkg::DATA_W-1:0]                     rd_data,
  output logic                                            rd_valid,
  // Lane status from the datapath
  input  wire rxsr_pkg::rxsr_lane_stat_type [rxsr_pkg::LANES-1:0] lane_stat,
  input  wire logic [rxsr_pkg::LANES-1:0]                 lane_en,
  // Timing reference and resync
  input  wire logic                                       sysref_pin,
  input  wire logic                                       resync_req,
  // Controls to the datapath
  output logic [rxsr_pkg::THR_W:0]                        block_lock_count_limit,
  output logic                                            lmfc_align,
  output logic                                            link_run
);

  localparam logic [rxsr_pkg::LANES-1:0] BUILT_MASK =
    {rxsr_pkg::LANES{1'b1}} >> (rxsr_pkg::LANES - NUM_LANES);

  logic [rxsr_pkg::THR_W-1:0]         thr_r;
  logic [rxsr_pkg::DLY_W-1:0]         dly_r;
  logic                               need_sref_r;
  logic                               always_r;
  logic [2:0]                         sref_sync_r;
  logic                               sref_edge;
  logic [rxsr_pkg::DLY_MAX-2:0]       hist_r;
  logic                               sref_delayed;
  logic                               aligned_once_r;
  logic                               accept;
  rxsr_pkg::rxsr_link_state_type      state_r;
  rxsr_pkg::rxsr_link_state_type      state_nxt;
  logic [rxsr_pkg::LANES-1:0]         active;
  logic [rxsr_pkg::DATA_W-1:0]        err_r;
  logic [rxsr_pkg::DATA_W-1:0]        err_set;
  logic [rxsr_pkg::LANES-1:0]         sod_r;
  logic [rxsr_pkg::LANES-1:0]         ila_r;
  logic [rxsr_pkg::DATA_W-1:0]        lock_word;
  logic [rxsr_pkg::DATA_W-1:0]        dbg_word;
  logic [rxsr_pkg::DATA_W-1:0]        rd_data_nxt;
  logic                               wr_hit_thr;
  logic                               wr_hit_sref;
  logic                               rd_err;
  logic                               rd_dbg;

  assign active      = lane_en & BUILT_MASK;
  assign wr_hit_thr  = reg_req.wr && (reg_req.addr == rxsr_pkg::OFS_MBLOCK);
  assign wr_hit_sref = reg_req.wr && (reg_req.addr == rxsr_pkg::OFS_SYSREF);
  assign rd_err      = reg_req.rd && (reg_req.addr == rxsr_pkg::OFS_ERR);
  assign rd_dbg      = reg_req.rd && (reg_req.addr == rxsr_pkg::OFS_DEBUG);

  // Control registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      thr_r <= rxsr_pkg::THR_RST;
    end else if (wr_hit_thr) begin
      thr_r <= reg_req.wdata[rxsr_pkg::THR_LSB +: rxsr_pkg::THR_W];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dly_r       <= rxsr_pkg::DLY_RST;
      need_sref_r <= rxsr_pkg::RESYNC_RST;
      always_r    <= rxsr_pkg::ALWAYS_RST;
    end else if (wr_hit_sref) begin
      dly_r       <= reg_req.wdata[rxsr_pkg::DLY_LSB +: rxsr_pkg::DLY_W];
      need_sref_r <= reg_req.wdata[rxsr_pkg::RESYNC_BIT];
      always_r    <= reg_req.wdata[rxsr_pkg::ALWAYS_BIT];
    end
  end

  // Marker count is one more than the field, so zero still needs one marker
  assign block_lock_count_limit = {1'b0, thr_r} + 4'h1;

  // Pin crosses two flops; edge detect looks only past the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      sref_sync_r <= 3'h0;
    end else begin
      sref_sync_r <= {sref_sync_r[1:0], sysref_pin};
    end
  end
  assign sref_edge = sref_sync_r[1] && !sref_sync_r[2];

  // Delay line; a tap per cycle of retard
  always_ff @(posedge mclk) begin
    if (rst) begin
      hist_r <= '0;
    end else begin
      hist_r <= {hist_r[rxsr_pkg::DLY_MAX-3:0], sref_edge};
    end
  end

  always_comb begin
    if (dly_r == 4'h0) begin
      sref_delayed = sref_edge;
    end else begin
      sref_delayed = hist_r[dly_r - 4'h1];
    end
  end

  // An armed resync wait takes the next event even in first-only mode
  assign accept = always_r || !aligned_once_r || (state_r == rxsr_pkg::LINK_WAIT);
  assign lmfc_align = sref_delayed && accept;

  always_ff @(posedge mclk) begin
    if (rst) begin
      aligned_once_r <= 1'b0;
    end else if (lmfc_align) begin
      aligned_once_r <= 1'b1;
    end
  end

  // Link run control around a resync
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rxsr_pkg::LINK_RUN: begin
        if (resync_req) begin
          state_nxt = rxsr_pkg::LINK_HALT;
        end
      end
      rxsr_pkg::LINK_HALT: begin
        if (resync_req) begin
          state_nxt = rxsr_pkg::LINK_HALT;
        end else if (need_sref_r) begin
          state_nxt = rxsr_pkg::LINK_WAIT;
        end else begin
          state_nxt = rxsr_pkg::LINK_RUN;
        end
      end
      rxsr_pkg::LINK_WAIT: begin
        if (resync_req) begin
          state_nxt = rxsr_pkg::LINK_HALT;
        end else if (lmfc_align) begin
          state_nxt = rxsr_pkg::LINK_RUN;
        end
      end
      default: begin
        state_nxt = rxsr_pkg::LINK_HALT;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= rxsr_pkg::LINK_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign link_run = (state_r == rxsr_pkg::LINK_RUN);

  // Per-lane packing of status words
  always_comb begin
    lock_word = '0;
    dbg_word  = '0;
    err_set   = '0;
    for (int i = 0; i < rxsr_pkg::LANES; i++) begin
      lock_word[rxsr_pkg::MBA_LSB + i] = lane_stat[i].mb_al && active[i];
      lock_word[rxsr_pkg::SHA_LSB + i] = lane_stat[i].sh_al && active[i];
      err_set[i*rxsr_pkg::NIB_W +: rxsr_pkg::NIB_W] =
        {1'b0, lane_stat[i].err & {3{active[i]}}};
      dbg_word[i*rxsr_pkg::NIB_W + rxsr_pkg::DBG_SOD] = sod_r[i];
      dbg_word[i*rxsr_pkg::NIB_W + rxsr_pkg::DBG_ILA] = ila_r[i];
      dbg_word[i*rxsr_pkg::NIB_W + rxsr_pkg::DBG_CGS] = lane_stat[i].cgs && active[i];
      dbg_word[i*rxsr_pkg::NIB_W + rxsr_pkg::DBG_K28] = lane_stat[i].k28 && active[i];
    end
  end

  // Errors arriving during the clearing read stay set for the next read
  always_ff @(posedge mclk) begin
    if (rst) begin
      err_r <= '0;
    end else if (rd_err) begin
      err_r <= err_set;
    end else begin
      err_r <= err_r | err_set;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sod_r <= '0;
      ila_r <= '0;
    end else if (rd_dbg) begin
      for (int i = 0; i < rxsr_pkg::LANES; i++) begin
        sod_r[i] <= lane_stat[i].sod && active[i];
        ila_r[i] <= lane_stat[i].ila && active[i];
      end
    end else begin
      for (int i = 0; i < rxsr_pkg::LANES; i++) begin
        sod_r[i] <= sod_r[i] || (lane_stat[i].sod && active[i]);
        ila_r[i] <= ila_r[i] || (lane_stat[i].ila && active[i]);
      end
    end
  end

  // Read decode; unmapped offsets read zero
  always_comb begin
    if (reg_req.addr == rxsr_pkg::OFS_MBLOCK) begin
      rd_data_nxt = {29'h0, thr_r};
    end else if (reg_req.addr == rxsr_pkg::OFS_SYSREF) begin
      rd_data_nxt = {12'h0, dly_r, 14'h0, need_sref_r, always_r};
    end else if (reg_req.addr == rxsr_pkg::OFS_LOCK) begin
      rd_data_nxt = lock_word;
    end else if (reg_req.addr == rxsr_pkg::OFS_ERR) begin
      rd_data_nxt = err_r;
    end else if (reg_req.addr == rxsr_pkg::OFS_DEBUG) begin
      rd_data_nxt = dbg_word;
    end else begin
      rd_data_nxt = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= reg_req.rd;
      if (reg_req.rd) begin
        rd_data <= rd_data_nxt;
      end
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_thr_write;
    wr_hit_thr;
  endsequence

  sequence s_resync_free;
    resync_req ##1 (!resync_req && !need_sref_r);
  endsequence

  sequence s_long_delay;
    sref_edge && (dly_r == 4'hF);
  endsequence

  sequence s_dbg_read;
    rd_dbg;
  endsequence

  a_lock_limit: assert property (s_thr_write |=>
    block_lock_count_limit == {1'b0, $past(reg_req.wdata[2:0])} + 4'h1)
    else $error("lock count limit not threshold plus one");

  a_sref_delay: assert property (s_long_delay |-> ##15
    ((dly_r != 4'hF) || !accept || lmfc_align))
    else $error("delayed alignment missing after fifteen cycles");

  a_resync_hold: assert property ((state_r == rxsr_pkg::LINK_WAIT) && !lmfc_align
    && !resync_req |=> !link_run)
    else $error("link ran before realignment");

  a_resync_free: assert property (s_resync_free |=> link_run)
    else $error("link did not restart after resync");

  a_resync_halt: assert property (resync_req |=> !link_run)
    else $error("link kept running through resync");

  a_wait_release: assert property ((state_r == rxsr_pkg::LINK_WAIT) && lmfc_align
    && !resync_req |=> link_run)
    else $error("link stayed halted after realignment");

  a_sref_zero: assert property (sref_edge && (dly_r == 4'h0) && accept
    |-> lmfc_align)
    else $error("undelayed alignment missing");

  a_every_sref: assert property (always_r && sref_delayed |-> lmfc_align)
    else $error("event ignored in align-always mode");

  a_first_only: assert property (aligned_once_r && !always_r
    && (state_r != rxsr_pkg::LINK_WAIT) |-> !lmfc_align)
    else $error("later event realigned in first-only mode");

  a_err_sticky: assert property (!rd_err |=>
    ((err_r & $past(err_r)) == $past(err_r)))
    else $error("error bit dropped without read");

  a_err_set: assert property ((err_set != '0) |=>
    ((err_r & $past(err_set)) == $past(err_set)))
    else $error("arriving error not recorded");

  a_err_clear: assert property (rd_err && (err_set == '0) |=>
    (err_r == '0) && (rd_data == $past(err_r)))
    else $error("error word not returned then cleared");

  a_err_unused: assert property (rd_valid |-> (err_r & 32'h88888888) == '0)
    else $error("unused error bit set");

  a_dbg_live: assert property (rd_dbg |=>
    rd_data[1:0] == ({$past(lane_stat[0].cgs), $past(lane_stat[0].k28)} & {2{$past(active[0])}}))
    else $error("debug live bits wrong");

  a_dbg_sticky: assert property (!rd_dbg |=>
    ((sod_r & $past(sod_r)) == $past(sod_r)) && ((ila_r & $past(ila_r)) == $past(ila_r)))
    else $error("detect latch dropped without read");

  a_dbg_reload: assert property (s_dbg_read |=>
    (sod_r[0] == ($past(lane_stat[0].sod) && $past(active[0]))))
    else $error("detect latch not reloaded on read");

  a_lock_read: assert property (reg_req.rd
    && (reg_req.addr == rxsr_pkg::OFS_LOCK) |=>
    (rd_data[16] == ($past(lane_stat[0].mb_al) && $past(active[0])))
    && (rd_data[0] == ($past(lane_stat[0].sh_al) && $past(active[0]))))
    else $error("lane zero lock flags wrong");

  a_lane_mask: assert property ((reg_req.rd && reg_req.addr == rxsr_pkg::OFS_LOCK) |=>
    ((rd_data[23:16] | rd_data[7:0]) & ~$past(active)) == '0)
    else $error("inactive lane flag reads one");

endmodule : rxsr_regs

/* rtl/rxsr_pkg.sv */
package rxsr_pkg;

  // Bus shape
  localparam int          LANES       = 8;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          NIB_W       = 4;

  // Register offsets (byte addresses, one word each)
  localparam logic [7:0]  OFS_MBLOCK  = 8'h00;
  localparam logic [7:0]  OFS_SYSREF  = 8'h04;
  localparam logic [7:0]  OFS_LOCK    = 8'h08;
  localparam logic [7:0]  OFS_ERR     = 8'h0C;
  localparam logic [7:0]  OFS_DEBUG   = 8'h10;

  // Field positions
  localparam int          THR_LSB     = 0;
  localparam int          THR_W       = 3;
  localparam int          DLY_LSB     = 16;
  localparam int          DLY_W       = 4;
  localparam int          RESYNC_BIT  = 1;
  localparam int          ALWAYS_BIT  = 0;
  localparam int          MBA_LSB     = 16;
  localparam int          SHA_LSB     = 0;
  localparam int          ERR_UCHAR   = 2;
  localparam int          ERR_DISP    = 1;
  localparam int          ERR_NIT     = 0;
  localparam int          DBG_SOD     = 3;
  localparam int          DBG_ILA     = 2;
  localparam int          DBG_CGS     = 1;
  localparam int          DBG_K28     = 0;

  // Reset values
  localparam logic [2:0]  THR_RST     = 3'h0;
  localparam logic [3:0]  DLY_RST     = 4'h0;
  localparam logic        RESYNC_RST  = 1'b0;
  localparam logic        ALWAYS_RST  = 1'b0;

  // Timing-reference delay settings 0 to 15; the line has one stage fewer, one per core clock
  localparam int          DLY_MAX     = 16;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rxsr_reg_req_type;

  typedef struct packed {
    logic [2:0] err;
    logic       sod;
    logic       ila;
    logic       cgs;
    logic       k28;
    logic       mb_al;
    logic       sh_al;
  } rxsr_lane_stat_type;

  typedef enum logic [1:0] {
    LINK_RUN  = 2'b00,
    LINK_HALT = 2'b01,
    LINK_WAIT = 2'b11
  } rxsr_link_state_type;

endpackage : rxsr_pkg

/* dv/rxsr_far_end.sv */
`timescale 1ns/100ps
// Transmitter side as the lane datapath reports it, plus the timing reference
module rxsr_far_end (
  // Clock
  input  wire logic                                         mclk,
  // Lane status and timing reference
  output rxsr_pkg::rxsr_lane_stat_type [rxsr_pkg::LANES-1:0] lane_stat,
  output logic                                              sysref_pin
);
  initial begin
    lane_stat  = '0;
    sysref_pin = 1'b0;
  end

  // Live levels hold until changed
  task automatic live(input logic [7:0] mb, sh, cgs, k28);
    for (int i = 0; i < rxsr_pkg::LANES; i++) begin
      lane_stat[i].mb_al = mb[i];
      lane_stat[i].sh_al = sh[i];
      lane_stat[i].cgs   = cgs[i];
      lane_stat[i].k28   = k28[i];
    end
  endtask : live

  // One-cycle events, launched off the sampling edge
  task automatic pulse(input logic [7:0][2:0] err, input logic [7:0] sod, ila);
    @(negedge mclk);
    for (int i = 0; i < rxsr_pkg::LANES; i++) begin
      lane_stat[i].err = err[i];
      lane_stat[i].sod = sod[i];
      lane_stat[i].ila = ila[i];
    end
    @(negedge mclk);
    for (int i = 0; i < rxsr_pkg::LANES; i++) begin
      lane_stat[i].err = 3'h0;
      lane_stat[i].sod = 1'b0;
      lane_stat[i].ila = 1'b0;
    end
  endtask : pulse

  // Start-of-data as a level, as while a lane keeps streaming
  task automatic stream(input logic [7:0] sod);
    for (int i = 0; i < rxsr_pkg::LANES; i++) lane_stat[i].sod = sod[i];
  endtask : stream

  // Held three cycles so the synchroniser cannot miss it
  task automatic sref();
    sysref_pin = 1'b1;
    repeat (3) @(negedge mclk);
    sysref_pin = 1'b0;
  endtask : sref
endmodule : rxsr_far_end

/* dv/rxsr_regs_bench.sv */
`timescale 1ns/100ps
module rxsr_regs_bench;
  logic                                             mclk;
  logic                                             rst;
  rxsr_pkg::rxsr_reg_req_type                       reg_req;
  logic [31:0]                                      rd_data;
  logic                                             rd_valid;
  rxsr_pkg::rxsr_lane_stat_type [rxsr_pkg::LANES-1:0] lane_stat;
  logic [7:0]                                       lane_en;
  logic                                             sysref_pin;
  logic                                             resync_req;
  logic [3:0]                                       block_lock_count_limit;
  logic                                             lmfc_align;
  logic                                             link_run;
  int                                               miscompares;
  int                                               total_checks;
  int                                               n0;
  int                                               n;
  logic [7:0][2:0]                                  errs;

  rxsr_regs u_rxsr_regs (.mclk(mclk), .rst(rst), .reg_req(reg_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .lane_stat(lane_stat), .lane_en(lane_en), .sysref_pin(sysref_pin),
    .resync_req(resync_req), .block_lock_count_limit(block_lock_count_limit),
    .lmfc_align(lmfc_align), .link_run(link_run));
  rxsr_far_end far (.mclk(mclk), .lane_stat(lane_stat), .sysref_pin(sysref_pin));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk);
    reg_req.wr = 1'b0;
  endtask : wr

  // Answer may land one edge late; a bounded wait keeps a lost answer visible
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    int k;
    @(negedge mclk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(negedge mclk);
    reg_req.rd = 1'b0;
    k = 0;
    while (rd_valid !== 1'b1 && k < 3) begin
      @(negedge mclk);
      k++;
    end
    chk({31'h0, rd_valid}, 32'h1);
    chk(rd_data, exp);
  endtask : rd_chk

  task automatic align_time(output int cnt);
    @(negedge mclk);
    fork
      far.sref();
    join_none
    cnt = 0;
    while (lmfc_align !== 1'b1 && cnt < 40) begin
      @(negedge mclk);
      cnt++;
    end
    repeat (10) @(negedge mclk);
  endtask : align_time

  task automatic resync_pulse();
    @(negedge mclk);
    resync_req = 1'b1;
    @(negedge mclk);
    resync_req = 1'b0;
  endtask : resync_pulse

  task automatic do_reset();
    @(negedge mclk);
    rst = 1'b1;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
  endtask : do_reset

  task automatic t_reset();
    chk({28'h0, block_lock_count_limit}, 32'h1);
    chk({31'h0, link_run}, 32'h1);
    rd_chk(rxsr_pkg::OFS_MBLOCK, 32'h0);
    rd_chk(rxsr_pkg::OFS_SYSREF, 32'h0);
  endtask : t_reset

  task automatic t_thresh();
    for (int v = 0; v < 8; v++) begin
      wr(rxsr_pkg::OFS_MBLOCK, 32'(v));
      chk({28'h0, block_lock_count_limit}, 32'(v + 1));
      rd_chk(rxsr_pkg::OFS_MBLOCK, 32'(v));
    end
  endtask : t_thresh

  // Delay is judged relative to the zero-delay latency of the synchroniser
  task automatic t_delay();
    wr(rxsr_pkg::OFS_SYSREF, 32'h1);
    align_time(n0);
    chk(32'(n0 < 40), 32'h1);
    wr(rxsr_pkg::OFS_SYSREF, 32'h0005_0001);
    align_time(n);
    chk(32'(n), 32'(n0 + 5));
    wr(rxsr_pkg::OFS_SYSREF, 32'h000F_0001);
    rd_chk(rxsr_pkg::OFS_SYSREF, 32'h000F_0001);
    align_time(n);
    chk(32'(n), 32'(n0 + 15));
  endtask : t_delay

  task automatic t_first();
    do_reset();
    align_time(n);
    chk(32'(n), 32'(n0));
    align_time(n);
    chk(32'(n), 32'd40);
  endtask : t_first

  task automatic t_resync();
    resync_pulse();
    chk({31'h0, link_run}, 32'h0);
    @(negedge mclk);
    chk({31'h0, link_run}, 32'h1);
    wr(rxsr_pkg::OFS_SYSREF, 32'h2);
    resync_pulse();
    repeat (10) @(negedge mclk);
    chk({31'h0, link_run}, 32'h0);
    align_time(n);
    chk(32'(n), 32'(n0));
    chk({31'h0, link_run}, 32'h1);
  endtask : t_resync

  task automatic t_lock();
    lane_en = 8'h7F;
    far.live(8'hA5, 8'h3C, 8'h00, 8'h00);
    rd_chk(rxsr_pkg::OFS_LOCK, 32'h0025_003C);
  endtask : t_lock

  // Lane 7 disabled; a second burst on lane 0 must accumulate
  task automatic t_err();
    for (int l = 0; l < 8; l++) errs[l] = 3'(l % 7 + 1);
    far.pulse(errs, 8'h00, 8'h00);
    errs = '0;
    errs[0] = 3'h4;
    far.pulse(errs, 8'h00, 8'h00);
    repeat (5) @(negedge mclk);
    rd_chk(rxsr_pkg::OFS_ERR, 32'h0765_4325);
    rd_chk(rxsr_pkg::OFS_ERR, 32'h0);
  endtask : t_err

  task automatic t_debug();
    far.live(8'h00, 8'h00, 8'h88, 8'h10);
    far.pulse('0, 8'h82, 8'h04);
    rd_chk(rxsr_pkg::OFS_DEBUG, 32'h0001_2480);
    rd_chk(rxsr_pkg::OFS_DEBUG, 32'h0001_2000);
    far.stream(8'h01);
    rd_chk(rxsr_pkg::OFS_DEBUG, 32'h0001_2008);
    rd_chk(rxsr_pkg::OFS_DEBUG, 32'h0001_2008);
    far.stream(8'h00);
    far.live(8'h00, 8'h00, 8'h00, 8'h00);
    rd_chk(rxsr_pkg::OFS_DEBUG, 32'h0000_0008);
    rd_chk(rxsr_pkg::OFS_DEBUG, 32'h0);
  endtask : t_debug

  task automatic t_refuse();
    wr(rxsr_pkg::OFS_LOCK, 32'hFFFF_FFFF);
    rd_chk(rxsr_pkg::OFS_LOCK, 32'h0);
    rd_chk(8'h40, 32'h0);
  endtask : t_refuse

  initial begin
    rst = 1'b1;
    reg_req = '0;
    lane_en = 8'hFF;
    resync_req = 1'b0;
    miscompares = 0;
    total_checks = 0;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_thresh();
    t_delay();
    t_first();
    t_resync();
    t_lock();
    t_err();
    t_debug();
    t_refuse();
    close_out();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    #40000;
    miscompares++;
    close_out();
  end
endmodule : rxsr_regs_bench
